// >>> common/sasc_pkg.sv
// Constants and types shared by the servo actuator state control block
package sasc_pkg;

  // Position, address, error and diagnostic widths
  localparam int POS_W = 8;
  localparam int ADDR_W = 4;
  localparam int ERR_W = 4;
  localparam int DIAG_W = 4;

  // Slave addressing: one master, at most this many slaves
  localparam logic [4:0] MAX_SLAVES = 5'h0F;

  // Position thresholds
  localparam logic [7:0] POS_ZERO = 8'h00;
  localparam logic [7:0] POS_FULL_OPEN = 8'h00;
  localparam logic [7:0] POS_FULL_CLOSED = 8'hFF;
  localparam logic [7:0] NEAR_LIMIT_LO = 8'h10;
  localparam logic [7:0] NEAR_LIMIT_HI = 8'hEF;

  // Drive power levels
  localparam logic [1:0] PWR_OFF = 2'h0;
  localparam logic [1:0] PWR_REDUCED = 2'h1;
  localparam logic [1:0] PWR_FULL = 2'h3;

  // State clock timing: tick period in ns, derived cycle count
  localparam int TICK_NS = 1000;
  localparam int CLK_NS = 4;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

  // Settling delay in state clock ticks
  localparam logic [3:0] SETTLE_TICKS = 4'h4;

  // Driver diagnostic bit positions
  localparam int DIAG_OT = 0;
  localparam int DIAG_OV = 1;
  localparam int DIAG_UV = 2;
  localparam int DIAG_OC = 3;

  // Controller states, one-hot
  typedef enum logic [8:0] {
    ST_HOME        = 9'h001,
    ST_STOP        = 9'h002,
    ST_CW          = 9'h004,
    ST_CCW         = 9'h008,
    ST_SLEEP       = 9'h010,
    ST_OPEN_LOOP   = 9'h020,
    ST_REPROGRAM   = 9'h040,
    ST_TERM_FAULT  = 9'h080,
    ST_RESERVED    = 9'h100
  } sasc_state_type;

endpackage

// >>> hdl/sasc_tick_gen.sv
// Periodic state clock tick generator
`timescale 1ns/1ps
module sasc_tick_gen
  import sasc_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rst, // Async reset, active high
  output logic tick // One-cycle state clock tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } sasc_tick_type;

  sasc_tick_type s_q;
  sasc_tick_type s_d;

  // Free-running divider; ticks never depend on any other activity
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == TICK_LAST) begin
      s_d.cnt = 8'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

// >>> hdl/sasc_ctrl.sv
// Servo actuator control state machine with status reporting
`timescale 1ns/1ps
module sasc_ctrl
  import sasc_pkg::*;
(
  input wire logic ref_clk, // System clock, 250 MHz
  input wire logic rst, // Async reset, active high
  input wire logic cmd_valid, // Input command frame pulse
  input wire logic [3:0] cmd_addr, // Slot address of the command
  input wire logic [7:0] cmd_target, // Target position
  input wire logic stat_req, // Status request pulse
  input wire logic prog_valid, // Programming command pulse
  input wire logic [3:0] prog_addr, // New node address
  input wire logic sleep_msg, // Sleep message pulse
  input wire logic fb_fault, // Feedback fault level
  input wire logic [7:0] fb_pos, // Feedback position reading
  input wire logic [3:0] drv_diag, // Driver diagnostics level
  input wire logic [3:0] link_err, // Link messaging error codes
  output logic stat_valid, // Status response pulse
  output logic [7:0] stat_pos, // Reported position
  output logic [7:0] stat_cmd, // Command being acted upon
  output logic [3:0] stat_diag, // Reported driver diagnostics
  output logic [3:0] stat_err, // Reported link errors
  output logic [8:0] stat_state, // Reported state code
  output logic bridge_cw, // H-bridge clockwise enable
  output logic bridge_ccw, // H-bridge counter-clockwise enable
  output logic [1:0] bridge_pwr, // H-bridge power level
  output logic [3:0] node_addr // Programmed node address
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    sasc_state_type st;
    logic [7:0] target;
    logic [3:0] addr;
    logic was_moving;
    logic [3:0] settle;
    logic homed;
    logic stat_valid;
    logic [7:0] stat_pos;
    logic [7:0] stat_cmd;
    logic [3:0] stat_diag;
    logic [3:0] stat_err;
    logic [8:0] stat_state;
    logic bridge_cw;
    logic bridge_ccw;
    logic [1:0] bridge_pwr;
    logic sleep_pend;
  } sasc_ctrl_type;

  sasc_ctrl_type s_q;
  sasc_ctrl_type s_d;
  logic tick;
  logic cmd_hit;
  logic at_target;
  logic need_cw;
  logic need_ccw;
  logic drv_cut;

  // ----------------------------------------------------------------
  // State clock
  // ----------------------------------------------------------------
  sasc_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // own slot only
  assign cmd_hit = cmd_valid && (cmd_addr == s_q.addr);
  assign at_target = (fb_pos == s_q.target);
  assign need_cw = (fb_pos < s_q.target);
  assign need_ccw = (fb_pos > s_q.target);
  // Over-temperature and over-voltage make the bridge cut itself
  assign drv_cut = drv_diag[DIAG_OT] | drv_diag[DIAG_OV];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.stat_valid = 1'b0;
    if (prog_valid) begin
      s_d.addr = prog_addr;
    end
    if (cmd_hit) begin
      if (s_q.st == ST_OPEN_LOOP) begin
        if (cmd_target == POS_FULL_OPEN ||
            cmd_target == POS_FULL_CLOSED) begin
          s_d.target = cmd_target;
        end
      end else begin
        s_d.target = cmd_target;
      end
    end
    s_d.stat_diag = drv_diag;
    s_d.stat_err = link_err;
    if (tick) begin
      unique case (s_q.st)
        ST_HOME: begin
          if (fb_pos == POS_ZERO) begin
            s_d.st = ST_STOP;
            s_d.was_moving = 1'b1;
            s_d.settle = SETTLE_TICKS;
            s_d.homed = 1'b1;
          end
        end
        ST_STOP: begin
          if (s_q.was_moving && s_q.settle != 4'h0) begin
            s_d.settle = s_q.settle - 4'h1;
          end else begin
            s_d.was_moving = 1'b0;
            if (s_q.sleep_pend) begin
              s_d.st = ST_SLEEP;
              s_d.sleep_pend = 1'b0;
            end else if (fb_fault) begin
              s_d.st = ST_OPEN_LOOP;
            end else if (need_cw) begin
              s_d.st = ST_CW;
            end else if (need_ccw) begin
              s_d.st = ST_CCW;
            end
          end
        end
        ST_CW: begin
          if (!need_cw || fb_fault || s_q.sleep_pend) begin
            s_d.st = ST_STOP;
            s_d.was_moving = 1'b1;
            s_d.settle = SETTLE_TICKS;
          end
        end
        ST_CCW: begin
          if (!need_ccw || fb_fault || s_q.sleep_pend) begin
            s_d.st = ST_STOP;
            s_d.was_moving = 1'b1;
            s_d.settle = SETTLE_TICKS;
          end
        end
        ST_SLEEP, ST_OPEN_LOOP, ST_REPROGRAM, ST_TERM_FAULT,
        ST_RESERVED: begin
          s_d.st = s_q.st;
        end
        default: begin
          s_d.st = ST_STOP;
        end
      endcase
    end
    // Sleep set after the tick clear, so a new message is never lost
    if (sleep_msg) begin
      s_d.sleep_pend = 1'b1;
    end
    // Bridge outputs follow the state being entered, registered along with it
    s_d.bridge_cw = 1'b0;
    s_d.bridge_ccw = 1'b0;
    s_d.bridge_pwr = PWR_OFF;
    unique case (s_d.st)
      ST_HOME: begin
        s_d.bridge_ccw = 1'b1;
        s_d.bridge_pwr = PWR_FULL;
      end
      ST_CW: begin
        s_d.bridge_cw = 1'b1;
        s_d.bridge_pwr = (fb_pos >= NEAR_LIMIT_HI) ? PWR_REDUCED
                                                   : PWR_FULL;
      end
      ST_CCW: begin
        s_d.bridge_ccw = 1'b1;
        s_d.bridge_pwr = (fb_pos <= NEAR_LIMIT_LO) ? PWR_REDUCED
                                                   : PWR_FULL;
      end
      default: begin
        s_d.bridge_pwr = PWR_OFF;
      end
    endcase
    if (drv_cut) begin
      s_d.bridge_pwr = PWR_OFF;
    end
    if (stat_req) begin
      s_d.stat_valid = 1'b1;
      s_d.stat_pos = fb_pos;
      s_d.stat_cmd = s_q.target;
      s_d.stat_state = s_q.st;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Home with the bridge off at reset release; it starts driving one cycle later
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= ST_HOME;
      s_q.stat_state <= ST_HOME;
    end else begin
      s_q <= s_d;
    end
  end

  assign stat_valid = s_q.stat_valid;
  assign stat_pos = s_q.stat_pos;
  assign stat_cmd = s_q.stat_cmd;
  assign stat_diag = s_q.stat_diag;
  assign stat_err = s_q.stat_err;
  assign stat_state = s_q.stat_state;
  assign bridge_cw = s_q.bridge_cw;
  assign bridge_ccw = s_q.bridge_ccw;
  assign bridge_pwr = s_q.bridge_pwr;
  assign node_addr = s_q.addr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_direct_rev: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == ST_CW) |=> (s_q.st != ST_CCW))
    else $error("direct reversal to ccw");

  a_no_rev_back: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == ST_CCW) |=> (s_q.st != ST_CW))
    else $error("direct reversal to cw");

  a_state_on_tick: assert property (@(posedge ref_clk) disable iff (rst)
    !tick |=> $stable(s_q.st))
    else $error("state changed without tick");

  a_cw_bridge_on: assert property (@(posedge ref_clk) disable iff (rst)
    (s_d.st == ST_CW) |=> (bridge_cw && !bridge_ccw))
    else $error("cw state without cw bridge");

  a_cut_power_off: assert property (@(posedge ref_clk) disable iff (rst)
    drv_cut |=> (bridge_pwr == PWR_OFF))
    else $error("fault did not cut power");

  a_stop_no_power: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == ST_STOP) |-> (!bridge_cw && !bridge_ccw))
    else $error("power applied in stop");

  a_settle_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == ST_STOP && s_q.was_moving && s_q.settle != 4'h0)
    |=> (s_q.st == ST_STOP))
    else $error("left stop before settling");

  a_stat_answer: assert property (@(posedge ref_clk) disable iff (rst)
    stat_req |=> (stat_valid && stat_pos == $past(fb_pos)))
    else $error("status answer wrong");

  a_cw_reduce: assert property (@(posedge ref_clk) disable iff (rst)
    (s_d.st == ST_CW && fb_pos >= NEAR_LIMIT_HI && !drv_cut)
    |=> (bridge_pwr == PWR_REDUCED))
    else $error("cw power not reduced");

  a_open_filter: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == ST_OPEN_LOOP && cmd_hit && cmd_target != POS_FULL_OPEN &&
     cmd_target != POS_FULL_CLOSED)
    |=> $stable(s_q.target))
    else $error("open loop took invalid target");

endmodule

// >>> dv/sasc_master_model.sv
// Bus master model that commands and polls one actuator node
`timescale 1ns/1ps
module sasc_master_model
  import sasc_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic stat_valid, // Status response pulse
  output logic cmd_valid, // Command pulse
  output logic [3:0] cmd_addr, // Slot address
  output logic [7:0] cmd_target, // Target position
  output logic stat_req, // Status request pulse
  output logic prog_valid, // Programming pulse
  output logic [3:0] prog_addr, // New node address
  output logic sleep_msg // Sleep message pulse
);
  // -------------------------------------------------------------
  // Idle levels at time zero
  // -------------------------------------------------------------
  initial begin
    {cmd_valid, stat_req, prog_valid, sleep_msg} = 4'h0;
    {cmd_addr, prog_addr, cmd_target} = 16'h0;
  end

  // Kind 0 command, 1 programming, 2 sleep; one-cycle pulse each
  // single master framing
  task automatic send(input int kind, input logic [3:0] a,
                      input logic [7:0] t);
    @(negedge ref_clk);
    cmd_addr = a;
    prog_addr = a;
    cmd_target = t;
    cmd_valid = (kind == 0);
    prog_valid = (kind == 1);
    sleep_msg = (kind == 2);
    @(negedge ref_clk);
    {cmd_valid, prog_valid, sleep_msg} = 3'h0;
    // Released fields carry garbage, never the last value
    cmd_addr = ~a;
    prog_addr = ~a;
    cmd_target = ~t;
  endtask

  // Status poll, bounded wait for the response pulse
  task automatic status(output logic ok);
    int k;
    @(negedge ref_clk);
    stat_req = 1'b1;
    @(negedge ref_clk);
    stat_req = 1'b0;
    k = 0;
    while (stat_valid !== 1'b1 && k < 3) begin
      @(negedge ref_clk);
      k++;
    end
    ok = (stat_valid === 1'b1);
  endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the servo actuator state control block
`timescale 1ns/1ps
module testbench;
  import sasc_pkg::*;
  logic ref_clk, rst, cmd_valid, stat_req, prog_valid, sleep_msg, fb_fault;
  logic [3:0] cmd_addr, prog_addr, drv_diag, link_err, stat_diag, stat_err;
  logic [3:0] node_addr;
  logic [7:0] cmd_target, fb_pos, stat_pos, stat_cmd;
  logic [8:0] stat_state;
  logic [1:0] bridge_pwr, prev_br;
  logic stat_valid, bridge_cw, bridge_ccw, ok;
  int failures, cmp_count, cyc, last_chg, nchg, n;

  // -------------------------------------------------------------
  // Design, master and clocking
  // -------------------------------------------------------------
  sasc_ctrl dut (.ref_clk, .rst, .cmd_valid, .cmd_addr, .cmd_target,
    .stat_req, .prog_valid, .prog_addr, .sleep_msg, .fb_fault, .fb_pos,
    .drv_diag, .link_err, .stat_valid, .stat_pos, .stat_cmd, .stat_diag,
    .stat_err, .stat_state, .bridge_cw, .bridge_ccw, .bridge_pwr,
    .node_addr);
  sasc_master_model master (.ref_clk, .stat_valid, .cmd_valid, .cmd_addr,
    .cmd_target, .stat_req, .prog_valid, .prog_addr, .sleep_msg);

  // Free running 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Watchdog, well past the expected run of about 7.5k cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    results();
  end

  task automatic check(input string what, input logic [8:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Enable changes: no direct reversal, tick-aligned spacing
  // Sampled on the falling edge, away from the edge that launches them
  always @(negedge ref_clk or posedge rst) begin
    if (rst) begin
      cyc <= 0;
      nchg <= 0;
      prev_br <= 2'h0;
    end else begin
      cyc <= cyc + 1;
      prev_br <= {bridge_cw, bridge_ccw};
      if ({bridge_cw, bridge_ccw} !== prev_br) begin
        check("no reversal", 1'b1, prev_br == 2'h0 ||
          {bridge_cw, bridge_ccw} == 2'h0);
        if (nchg >= 2)
          check("tick spacing", 0, (cyc - last_chg) % TICK_CYC);
        nchg <= nchg + 1;
        last_chg <= cyc;
      end
    end
  end

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic do_reset;
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic wait_br(input logic [1:0] want, input int lim);
    n = 0;
    while ({bridge_cw, bridge_ccw} !== want && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    check("bridge enables", want, {bridge_cw, bridge_ccw});
  endtask

  task automatic t_home;
    do_reset();
    check("home dir", 2'h1, {bridge_cw, bridge_ccw});
    check("home pwr", PWR_FULL, bridge_pwr);
    fb_pos = POS_ZERO;
    wait_br(2'h0, 600);
    repeat (3 * TICK_CYC) @(negedge ref_clk);
    check("parked", 3'h0, {bridge_cw, bridge_ccw, |bridge_pwr});
  endtask

  task automatic t_status;
    fb_pos = 8'h5A;
    drv_diag = 4'h4;
    link_err = 4'h9;
    master.status(ok);
    check("stat valid", 1'b1, ok);
    check("stat pos", 8'h5A, stat_pos);
    check("stat diag", 4'h4, stat_diag);
    check("stat err", 4'h9, stat_err);
    check("stat state", ST_STOP, stat_state);
    drv_diag = 4'h0;
    link_err = 4'h0;
  endtask

  task automatic t_addr;
    master.send(0, 4'h3, 8'h80);
    master.status(ok);
    check("foreign slot", 8'h00, stat_cmd);
    master.send(1, 4'h3, 8'h00);
    check("node addr", 4'h3, node_addr);
    fb_pos = 8'h20;
    master.send(0, 4'h3, 8'h80);
    master.status(ok);
    check("stat cmd", 8'h80, stat_cmd);
  endtask

  task automatic t_cw;
    wait_br(2'h2, 2000);
    check("cw pwr", PWR_FULL, bridge_pwr);
    master.send(0, 4'h3, 8'hFF);
    fb_pos = 8'hF0;
    repeat (2) @(negedge ref_clk);
    check("cw reduced", PWR_REDUCED, bridge_pwr);
    drv_diag = 4'h1;
    repeat (2 * TICK_CYC) @(negedge ref_clk);
    check("cut pwr", PWR_OFF, bridge_pwr);
    master.status(ok);
    check("fault state", ST_CW, stat_state);
    check("fault diag", 4'h1, stat_diag);
    drv_diag = 4'h0;
  endtask

  task automatic t_reverse;
    master.send(0, 4'h3, 8'h00);
    wait_br(2'h0, 600);
    check("stop pwr", PWR_OFF, bridge_pwr);
    wait_br(2'h1, 2000);
    check("settled", 1'b1,
      n >= int'(SETTLE_TICKS) * TICK_CYC);
    // Near the low end the counter-clockwise drive backs off
    fb_pos = NEAR_LIMIT_LO;
    repeat (2) @(negedge ref_clk);
    check("ccw reduced", PWR_REDUCED, bridge_pwr);
    fb_pos = POS_ZERO;
    wait_br(2'h0, 600);
  endtask

  task automatic t_sleep;
    repeat (6 * TICK_CYC) @(negedge ref_clk);
    master.send(2, 4'h0, 8'h00);
    repeat (2 * TICK_CYC) @(negedge ref_clk);
    master.status(ok);
    check("sleep state", ST_SLEEP, stat_state);
    check("sleep pwr", PWR_OFF, bridge_pwr);
  endtask

  task automatic t_open;
    // Open loop is only reached from a settled stop, so home first
    do_reset();
    fb_pos = POS_ZERO;
    fb_fault = 1'b1;
    wait_br(2'h0, 600);
    repeat (6 * TICK_CYC) @(negedge ref_clk);
    fb_pos = 8'h33;
    master.status(ok);
    check("open state", ST_OPEN_LOOP, stat_state);
    check("raw pos", 8'h33, stat_pos);
    master.send(0, 4'h0, 8'h55);
    master.status(ok);
    check("mid refused", 8'h00, stat_cmd);
    master.send(0, 4'h0, POS_FULL_CLOSED);
    master.status(ok);
    check("full taken", POS_FULL_CLOSED, stat_cmd);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    fb_pos = 8'h50;
    fb_fault = 1'b0;
    drv_diag = 4'h0;
    link_err = 4'h0;
    failures = 0;
    cmp_count = 0;
    t_home();
    t_status();
    t_addr();
    t_cw();
    t_reverse();
    t_sleep();
    t_open();
    results();
  end
endmodule
